// *** inc/dtw_pkg.sv ***
// Constants and types shared by the DMA transfer width planner.
// Assumes one 250 MHz clock and a synchronous active-high reset.
// Function
// - Move data at 8, 16 or 32 bits
// - Reset selects single setup; option enables split
// - Bus width fixed; address, count per command
// - Aligned address: multiple of bus bytes
// - Non-aligned count: not multiple of bus bytes
// - Single mode programs hardware exactly once
// - Single mode, all aligned: 32-bit transfers
// - Single mode, word misalignment: 16-bit transfers
// - Single mode, odd misalignment: 8-bit transfers
// - Single mode raises one completion interrupt
// - Split mode, all aligned: one full setup
// - Split mode uses one to three setups
// - Split head moves leading bytes until aligned
// - Split body moves aligned data full width
// - Split tail moves trailing one to three bytes
// - Split mode interrupts once per setup
// - Offset one head: three single-byte transfers
// - After each setup advance address, lower count
// - Aligned count thirteen: three dwords, one byte
// - Aligned remainder after head: no tail
package dtw_pkg;

   localparam int unsigned BUS_BITS_DEF = 32;
   localparam int unsigned ADDR_W_DEF = 32;
   localparam int unsigned CNT_W_DEF = 24;
   localparam logic SPLIT_RST = 1'b0;

   // Code value doubles as the byte-to-beat shift
   typedef enum logic [1:0] {
      XW_8  = 2'h0,
      XW_16 = 2'h1,
      XW_32 = 2'h2
   } xfer_width_e;

   typedef enum logic [1:0] {
      PH_SINGLE = 2'h0,
      PH_HEAD   = 2'h1,
      PH_BODY   = 2'h2,
      PH_TAIL   = 2'h3
   } setup_phase_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_LOAD  = 2'h1,
      ST_OFFER = 2'h2,
      ST_RUN   = 2'h3
   } plan_state_e;

endpackage

// *** design/seg_planner.sv ***
// Combinational choice of the next setup from the running address and count.
// Assumes the caller only asks while the remaining count is non-zero.
`timescale 1ns/1ns
module seg_planner #(
   parameter int unsigned ADDR_W = dtw_pkg::ADDR_W_DEF,
   parameter int unsigned CNT_W = dtw_pkg::CNT_W_DEF,
   parameter int unsigned BUS_BYTES = 4
) (
   input wire logic [ADDR_W-1:0] i_addr, // Running address
   input wire logic [CNT_W-1:0] i_count, // Remaining bytes
   input wire logic i_split, // Split mode for this command
   output dtw_pkg::xfer_width_e o_width, // Width of the setup
   output logic [CNT_W-1:0] o_bytes, // Bytes moved by the setup
   output dtw_pkg::setup_phase_e o_phase // Role of the setup
);
   import dtw_pkg::*;

   localparam logic [1:0] AMASK = 2'(BUS_BYTES - 1);
   localparam logic [2:0] BUS_B3 = 3'(BUS_BYTES);
   localparam logic [CNT_W-1:0] BUS_BC = CNT_W'(BUS_BYTES);

   function automatic xfer_width_e full_width();
      if (BUS_BYTES == 4) begin
         return XW_32;
      end
      if (BUS_BYTES == 2) begin
         return XW_16;
      end
      return XW_8;
   endfunction

   // Pair on an even address only; anything else goes bytewise
   function automatic xfer_width_e frag_width(input logic [2:0] nbytes, input logic a0);
      if (nbytes == 3'h2 && !a0 && BUS_BYTES >= 2) begin
         return XW_16;
      end
      return XW_8;
   endfunction

   logic [1:0] off;
   logic [1:0] cnt_lo;
   logic [1:0] mis;
   logic [2:0] head_need;
   logic [2:0] head_bytes;

   always_comb begin
      off = i_addr[1:0] & AMASK;
      cnt_lo = i_count[1:0] & AMASK;
      mis = off | cnt_lo;
      head_need = BUS_B3 - {1'b0, off};
      head_bytes = (i_count < CNT_W'(head_need)) ? i_count[2:0] : head_need;
      o_width = full_width();
      o_bytes = i_count;
      o_phase = PH_SINGLE;
      if (!i_split) begin
         // Whole command in one width
         o_bytes = i_count;
         if (mis == 2'h0) begin
            o_width = full_width();
         end else if (!mis[0]) begin
            o_width = XW_16;
         end else begin
            o_width = XW_8;
         end
      end else if (off != 2'h0) begin
         o_phase = PH_HEAD;
         o_bytes = CNT_W'(head_bytes);
         o_width = frag_width(head_bytes, i_addr[0]);
      end else if (i_count >= BUS_BC) begin
         o_phase = PH_BODY;
         o_bytes = i_count & ~CNT_W'(AMASK);
         o_width = full_width();
      end else begin
         o_phase = PH_TAIL;
         o_bytes = i_count;
         o_width = frag_width(i_count[2:0], i_addr[0]);
      end
   end

endmodule // seg_planner

// *** design/dma_transfer_width_planner.sv ***
// Plans the bus-width setups for one command's DMA data between SCSI side
// and host memory. Issues setups one at a time to the transfer hardware.
// Assumes the transfer hardware takes a setup on ready and pulses done once.
`timescale 1ns/1ns
module dma_transfer_width_planner #(
   parameter int unsigned BUS_BITS = dtw_pkg::BUS_BITS_DEF,
   parameter int unsigned ADDR_W = dtw_pkg::ADDR_W_DEF,
   parameter int unsigned CNT_W = dtw_pkg::CNT_W_DEF
) (
   input wire logic i_clk, // 250 MHz adapter clock
   input wire logic i_rst, // Synchronous board reset
   input wire logic i_opt_valid, // Global options command strobe
   input wire logic i_opt_split, // Split-setup enable with the strobe
   input wire logic i_cmd_valid, // New command offered
   input wire logic [ADDR_W-1:0] i_cmd_addr, // Command start address
   input wire logic [CNT_W-1:0] i_cmd_count, // Command byte count
   input wire logic i_abort, // Drop the running command
   input wire logic i_setup_ready, // Transfer hardware takes setup
   input wire logic i_setup_done, // Transfer hardware finished setup
   output logic o_cmd_ready, // Idle, command may be offered
   output logic o_busy, // Command in progress
   output logic o_split_mode, // Split setups enabled
   output logic o_setup_valid, // Setup presented
   output logic [ADDR_W-1:0] o_setup_addr, // Setup start address
   output logic [CNT_W-1:0] o_setup_bytes, // Setup byte count
   output logic [CNT_W-1:0] o_setup_beats, // Setup transfer count
   output dtw_pkg::xfer_width_e o_setup_width, // Setup width code
   output dtw_pkg::setup_phase_e o_setup_phase, // Setup role
   output logic [1:0] o_setup_num, // Setups issued this command
   output logic o_irq, // Setup completion pulse
   output logic o_cmd_done, // Command finished pulse
   output logic o_cmd_aborted // Last command was aborted
);
   import dtw_pkg::*;

   localparam int unsigned BUS_BYTES = BUS_BITS / 8;

   // Bus width is elaboration-time only, never per command
   plan_state_e state_ff;
   plan_state_e nxt_state;

   logic split_en_ff;
   logic cmd_split_ff;
   logic [ADDR_W-1:0] run_addr_ff;
   logic [CNT_W-1:0] run_count_ff;

   logic setup_valid_ff;
   logic [ADDR_W-1:0] setup_addr_ff;
   logic [CNT_W-1:0] setup_bytes_ff;
   logic [CNT_W-1:0] setup_beats_ff;
   xfer_width_e setup_width_ff;
   setup_phase_e setup_phase_ff;
   logic [1:0] setup_num_ff;

   logic irq_ff;
   logic cmd_done_ff;
   logic cmd_aborted_ff;
   logic cmd_ready_ff;
   logic busy_ff;

   xfer_width_e plan_width;
   logic [CNT_W-1:0] plan_bytes;
   setup_phase_e plan_phase;

   logic cmd_take;
   logic seg_finish;
   logic last_seg;
   logic abort_hit;
   logic [CNT_W-1:0] nxt_count;

   seg_planner #(
      .ADDR_W(ADDR_W),
      .CNT_W(CNT_W),
      .BUS_BYTES(BUS_BYTES)
   ) u_plan (
      .i_addr(run_addr_ff),
      .i_count(run_count_ff),
      .i_split(cmd_split_ff),
      .o_width(plan_width),
      .o_bytes(plan_bytes),
      .o_phase(plan_phase)
   );

   // Beats from bytes; width code is the shift amount
   function automatic logic [CNT_W-1:0] beats_of(input logic [CNT_W-1:0] nbytes, input xfer_width_e w);
      return nbytes >> w;
   endfunction

   always_comb begin
      cmd_take = (state_ff == ST_IDLE) && i_cmd_valid;
      abort_hit = i_abort && (state_ff != ST_IDLE);
      seg_finish = (state_ff == ST_RUN) && i_setup_done && !i_abort;
      nxt_count = run_count_ff - setup_bytes_ff;
      last_seg = (nxt_count == '0);
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            // A zero count finishes at once with no setup
            if (cmd_take && i_cmd_count != '0) begin
               nxt_state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            nxt_state = ST_OFFER;
         end
         ST_OFFER: begin
            if (i_setup_ready) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            // Next setup only after this one is done
            if (i_setup_done) begin
               nxt_state = last_seg ? ST_IDLE : ST_LOAD;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (abort_hit) begin
         nxt_state = ST_IDLE;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Option changes never disturb a command already running
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         split_en_ff <= SPLIT_RST;
      end else if (i_opt_valid) begin
         split_en_ff <= i_opt_split;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cmd_split_ff <= 1'b0;
      end else if (cmd_take) begin
         cmd_split_ff <= split_en_ff;
      end
   end

   // Running address and count, fresh from every command
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         run_addr_ff <= '0;
         run_count_ff <= '0;
      end else if (cmd_take) begin
         run_addr_ff <= i_cmd_addr;
         run_count_ff <= i_cmd_count;
      end else if (seg_finish) begin
         run_addr_ff <= run_addr_ff + ADDR_W'(setup_bytes_ff);
         run_count_ff <= nxt_count;
      end
   end

   // Setup descriptor captured from the planner
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         setup_addr_ff <= '0;
         setup_bytes_ff <= '0;
         setup_beats_ff <= '0;
         setup_width_ff <= XW_8;
         setup_phase_ff <= PH_SINGLE;
      end else if (state_ff == ST_LOAD) begin
         setup_addr_ff <= run_addr_ff;
         setup_bytes_ff <= plan_bytes;
         setup_beats_ff <= beats_of(plan_bytes, plan_width);
         setup_width_ff <= plan_width;
         setup_phase_ff <= plan_phase;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         setup_valid_ff <= 1'b0;
      end else if (abort_hit) begin
         setup_valid_ff <= 1'b0;
      end else if (state_ff == ST_LOAD) begin
         setup_valid_ff <= 1'b1;
      end else if (state_ff == ST_OFFER && i_setup_ready) begin
         setup_valid_ff <= 1'b0;
      end
   end

   // Count of setups per command; at most three in split mode
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         setup_num_ff <= 2'h0;
      end else if (cmd_take) begin
         setup_num_ff <= 2'h0;
      end else if (state_ff == ST_LOAD) begin
         setup_num_ff <= setup_num_ff + 2'h1;
      end
   end

   // One pulse per finished setup; single mode has one setup only
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= seg_finish;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cmd_done_ff <= 1'b0;
      end else begin
         cmd_done_ff <= (seg_finish && last_seg) || abort_hit || (cmd_take && i_cmd_count == '0);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cmd_aborted_ff <= 1'b0;
      end else if (abort_hit) begin
         cmd_aborted_ff <= 1'b1;
      end else if (cmd_take) begin
         cmd_aborted_ff <= 1'b0;
      end
   end

   // Ready and busy follow the next state so they line up with it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cmd_ready_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         cmd_ready_ff <= (nxt_state == ST_IDLE);
         busy_ff <= (nxt_state != ST_IDLE);
      end
   end

   assign o_cmd_ready = cmd_ready_ff;
   assign o_busy = busy_ff;
   assign o_split_mode = split_en_ff;
   assign o_setup_valid = setup_valid_ff;
   assign o_setup_addr = setup_addr_ff;
   assign o_setup_bytes = setup_bytes_ff;
   assign o_setup_beats = setup_beats_ff;
   assign o_setup_width = setup_width_ff;
   assign o_setup_phase = setup_phase_ff;
   assign o_setup_num = setup_num_ff;
   assign o_irq = irq_ff;
   assign o_cmd_done = cmd_done_ff;
   assign o_cmd_aborted = cmd_aborted_ff;

endmodule // dma_transfer_width_planner

// *** test/xfer_hw_model.sv ***
// Transfer hardware model: takes a presented setup, later pulses done.
// Assumes the planner holds a setup until taken; a slow answer is selectable.
`timescale 1ns/1ns
module xfer_hw_model (
   input wire logic i_clk, // Clock
   input wire logic i_rst, // Reset
   input wire logic i_valid, // Setup presented
   input wire logic i_busy, // Planner busy
   input wire logic i_slow, // Stretch answers
   output logic o_ready, // Setup taken
   output logic o_done // Setup finished pulse
);
   logic [3:0] wait_ff;
   logic pend_ff;
   // Idle planner drops any pending work, so no stray done after abort
   always_ff @(posedge i_clk) begin
      o_ready <= 1'b0;
      o_done <= 1'b0;
      if (i_rst || !i_busy) begin
         pend_ff <= 1'b0;
         wait_ff <= 4'h0;
      end else if (wait_ff != 4'h0) begin
         wait_ff <= wait_ff - 4'h1;
      end else if (pend_ff) begin
         o_done <= 1'b1;
         pend_ff <= 1'b0;
         wait_ff <= i_slow ? 4'h5 : 4'h0;
      end else if (i_valid && o_ready) begin
         pend_ff <= 1'b1;
         wait_ff <= i_slow ? 4'h6 : 4'h1;
      end else if (i_valid) begin
         o_ready <= 1'b1;
      end
   end
endmodule // xfer_hw_model

// *** test/dma_transfer_width_planner_asserts.sv ***
// Checker for the transfer width planner, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module dtw_checker import dtw_pkg::*; #(
   parameter int unsigned BUS_BITS = 32,
   parameter int unsigned ADDR_W = 32,
   parameter int unsigned CNT_W = 24
) (
   input wire logic i_clk, input wire logic i_rst, input wire logic i_opt_valid, input wire logic i_opt_split,
   input wire logic i_cmd_valid, input wire logic [CNT_W-1:0] i_cmd_count, input wire logic i_abort,
   input wire logic i_setup_ready, input wire logic i_setup_done, input wire logic o_cmd_ready,
   input wire logic o_busy, input wire logic o_split_mode, input wire logic o_setup_valid,
   input wire logic [ADDR_W-1:0] o_setup_addr, input wire logic [CNT_W-1:0] o_setup_bytes,
   input wire logic [CNT_W-1:0] o_setup_beats, input dtw_pkg::xfer_width_e o_setup_width,
   input dtw_pkg::setup_phase_e o_setup_phase, input wire logic [1:0] o_setup_num, input wire logic o_irq,
   input wire logic o_cmd_done, input wire logic o_cmd_aborted
);
   localparam int BB = BUS_BITS / 8;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_ready_busy: assert property (!$past(i_rst) |-> o_cmd_ready != o_busy) else $error("ready busy clash");
   a_setup_start: assert property (i_cmd_valid && o_cmd_ready && i_cmd_count != 0 |-> ##2 o_setup_valid)
      else $error("no setup after take");
   a_zero_count: assert property (i_cmd_valid && o_cmd_ready && i_cmd_count == 0 |=> o_cmd_done && !o_setup_valid)
      else $error("zero count mishandled");
   a_hold_setup: assert property (o_setup_valid && !i_setup_ready && !i_abort |=> o_setup_valid &&
      $stable(o_setup_addr) && $stable(o_setup_bytes) && $stable(o_setup_width)) else $error("setup moved");
   a_beats_width: assert property (o_setup_valid |-> o_setup_beats == (o_setup_bytes >> o_setup_width))
      else $error("beats mismatch");
   a_body_full: assert property (o_setup_valid && o_setup_phase == PH_BODY |-> o_setup_width == $clog2(BB) &&
      o_setup_addr % BB == 0 && o_setup_bytes % BB == 0) else $error("body not full width");
   a_head_frag: assert property (o_setup_valid && o_setup_phase == PH_HEAD |-> o_setup_bytes inside {[1:3]} &&
      o_setup_width != XW_32 && o_setup_num == 2'h1) else $error("bad head");
   a_tail_frag: assert property (o_setup_valid && o_setup_phase == PH_TAIL |-> o_setup_bytes < BB &&
      o_setup_width != XW_32) else $error("bad tail");
   a_single_once: assert property (o_setup_valid && o_setup_phase == PH_SINGLE |-> o_setup_num == 2'h1)
      else $error("single not first");
   a_irq_cause: assert property (o_irq |-> $past(i_setup_done)) else $error("irq without done");
   a_split_opt: assert property (i_opt_valid |=> o_split_mode == $past(i_opt_split)) else $error("mode not set");
   a_abort_ends: assert property (i_abort && o_busy |=> o_cmd_done && o_cmd_aborted && o_cmd_ready && !o_setup_valid)
      else $error("abort not clean");
   c_tail3: cover property (o_setup_valid && o_setup_phase == PH_TAIL && o_setup_num == 2'h3);
   c_abort: cover property (o_cmd_aborted && o_cmd_done);
   c_zero: cover property (i_cmd_valid && o_cmd_ready && i_cmd_count == 0);
endmodule // dtw_checker

bind dma_transfer_width_planner dtw_checker #(.BUS_BITS(BUS_BITS), .ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_chk (
   .i_clk(i_clk), .i_rst(i_rst), .i_opt_valid(i_opt_valid), .i_opt_split(i_opt_split), .i_cmd_valid(i_cmd_valid),
   .i_cmd_count(i_cmd_count), .i_abort(i_abort), .i_setup_ready(i_setup_ready), .i_setup_done(i_setup_done),
   .o_cmd_ready(o_cmd_ready), .o_busy(o_busy), .o_split_mode(o_split_mode), .o_setup_valid(o_setup_valid),
   .o_setup_addr(o_setup_addr), .o_setup_bytes(o_setup_bytes), .o_setup_beats(o_setup_beats),
   .o_setup_width(o_setup_width), .o_setup_phase(o_setup_phase), .o_setup_num(o_setup_num), .o_irq(o_irq),
   .o_cmd_done(o_cmd_done), .o_cmd_aborted(o_cmd_aborted));

// *** test/test_dma_transfer_width_planner.sv ***
// Testbench: directed and random commands in both modes, one abort.
// Assumes a 32-bit bus and the transfer hardware model at the far side.
`timescale 1ns/1ns
module test_dma_transfer_width_planner import dtw_pkg::*;;
   typedef struct {logic [31:0] a; logic [23:0] b; logic [1:0] w; int ph; logic [1:0] n;} exp_s;
   logic i_clk = 0, i_rst = 1, i_opt_valid = 0, i_opt_split = 0, i_cmd_valid = 0, i_abort = 0, slow = 0;
   logic [31:0] i_cmd_addr = 0;
   logic [23:0] i_cmd_count = 0;
   logic i_setup_ready, i_setup_done, o_cmd_ready, o_busy, o_split_mode, o_setup_valid, o_irq, o_cmd_done;
   logic o_cmd_aborted;
   logic [31:0] o_setup_addr;
   logic [23:0] o_setup_bytes, o_setup_beats;
   xfer_width_e o_setup_width;
   setup_phase_e o_setup_phase;
   logic [1:0] o_setup_num;
   exp_s exp_q[$];
   exp_s e;
   int num_errors = 0, n_checks = 0, irq_cnt = 0, nset = 0;
   always #2 i_clk = ~i_clk;
   dma_transfer_width_planner dut (.i_clk(i_clk), .i_rst(i_rst), .i_opt_valid(i_opt_valid),
      .i_opt_split(i_opt_split), .i_cmd_valid(i_cmd_valid), .i_cmd_addr(i_cmd_addr), .i_cmd_count(i_cmd_count),
      .i_abort(i_abort), .i_setup_ready(i_setup_ready), .i_setup_done(i_setup_done), .o_cmd_ready(o_cmd_ready),
      .o_busy(o_busy), .o_split_mode(o_split_mode), .o_setup_valid(o_setup_valid), .o_setup_addr(o_setup_addr),
      .o_setup_bytes(o_setup_bytes), .o_setup_beats(o_setup_beats), .o_setup_width(o_setup_width),
      .o_setup_phase(o_setup_phase), .o_setup_num(o_setup_num), .o_irq(o_irq), .o_cmd_done(o_cmd_done),
      .o_cmd_aborted(o_cmd_aborted));
   xfer_hw_model u_hw (.i_clk(i_clk), .i_rst(i_rst), .i_valid(o_setup_valid), .i_busy(o_busy), .i_slow(slow),
      .o_ready(i_setup_ready), .o_done(i_setup_done));
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", nm, x, g);
      end
   endtask
   task automatic push(input logic [31:0] a, input int b, input int w, input int ph);
      exp_s s;
      nset++;
      s.a = a; s.b = b[23:0]; s.w = w[1:0]; s.ph = ph; s.n = nset[1:0];
      exp_q.push_back(s);
   endtask
   // Expected setups worked out from the alignment of address and count
   task automatic plan(input logic [31:0] a, input int c, input bit sp);
      int h, bd, t, lo;
      logic [31:0] ta;
      nset = 0;
      lo = a[1:0] | c[1:0];
      if (!sp || lo == 0) begin
         if (c != 0) push(a, c, lo == 0 ? 2 : (lo[0] ? 0 : 1), sp ? -1 : 0);
         return;
      end
      h = (4 - a[1:0]) % 4;
      if (h > c) h = c;
      bd = (c - h) / 4 * 4;
      t = c - h - bd;
      ta = a + h + bd;
      if (h != 0) push(a, h, (h == 2 && !a[0]) ? 1 : 0, 1);
      if (bd != 0) push(a + h, bd, 2, 2);
      if (t != 0) push(ta, t, (t == 2 && !ta[0]) ? 1 : 0, 3);
   endtask
   always @(posedge i_clk) begin
      if (!i_rst && o_irq === 1'b1) irq_cnt++;
      if (!i_rst && o_setup_valid === 1'b1 && i_setup_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            num_errors++;
            $display("[FAIL] setup expected none seen %0h", o_setup_addr);
         end else begin
            e = exp_q.pop_front();
            chk("setup_addr", e.a, o_setup_addr);
            chk("setup_bytes", 32'(e.b), 32'(o_setup_bytes));
            chk("setup_width", 32'(e.w), 32'(o_setup_width));
            chk("setup_beats", 32'(e.b >> e.w), 32'(o_setup_beats));
            chk("setup_num", 32'(e.n), 32'(o_setup_num));
            if (e.ph >= 0) chk("setup_phase", 32'(e.ph), 32'(o_setup_phase));
         end
      end
   end
   task automatic set_split(input bit v);
      @(posedge i_clk);
      i_opt_valid <= 1'b1;
      i_opt_split <= v;
      @(posedge i_clk);
      i_opt_valid <= 1'b0;
      @(posedge i_clk);
      chk("split_mode", 32'(v), 32'(o_split_mode));
   endtask
   task automatic run_cmd(input logic [31:0] a, input int c, input bit sp, input bit ab);
      int i;
      plan(a, c, sp);
      irq_cnt = 0;
      for (i = 0; i < 50 && o_cmd_ready !== 1'b1; i++) @(posedge i_clk);
      if (i == 50) begin num_errors++; summarize(); end
      i_cmd_addr <= a;
      i_cmd_count <= c[23:0];
      i_cmd_valid <= 1'b1;
      @(posedge i_clk);
      i_cmd_valid <= 1'b0;
      for (i = 0; i < 400 && o_cmd_done !== 1'b1; i++) begin
         @(posedge i_clk);
         i_abort <= ab && o_irq === 1'b1;
      end
      if (i == 400) begin num_errors++; summarize(); end
      @(negedge i_clk);
      if (ab) chk("aborted", 1, 32'(o_cmd_aborted));
      else chk("irq_count", nset, irq_cnt);
      if (!ab) chk("setups_left", 0, exp_q.size());
      chk("busy_after_done", 0, 32'(o_busy));
      chk("ready_after_done", 1, 32'(o_cmd_ready));
      exp_q.delete();
      @(posedge i_clk);
   endtask
   initial begin
      void'($urandom(99));
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      chk("split_reset", 0, 32'(o_split_mode));
      run_cmd(0, 12, 0, 0);
      run_cmd(2, 12, 0, 0);
      run_cmd(0, 13, 0, 0);
      run_cmd(1, 0, 0, 0);
      set_split(1);
      run_cmd(0, 12, 1, 0);
      run_cmd(0, 13, 1, 0);
      run_cmd(1, 12, 1, 0);
      run_cmd(2, 12, 1, 0);
      run_cmd(3, 13, 1, 0);
      run_cmd(1, 14, 1, 1);
      repeat (16) begin
         slow <= 1'($urandom % 2);
         set_split(1'($urandom % 2));
         run_cmd($urandom, 8 + $urandom % 40, o_split_mode, 0);
      end
      summarize();
   end
endmodule // test_dma_transfer_width_planner
